// ==== rtl/programmable_function_unit.sv ====
// Four-slice function unit: tables, wide muxes, ripple arithmetic, distributed RAM/ROM
`timescale 1ns/1ps
module programmable_function_unit #(
  parameter bit HAS_RAM = 1'b1 // 0 builds the unit without RAM
) (
  input wire logic pclk, // APB and fabric clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [slice_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [3:0] tab0_a, // Table 0 input a, per slice
  input wire logic [3:0] tab0_b, // Table 0 input b
  input wire logic [3:0] tab0_c, // Table 0 input c
  input wire logic [3:0] tab0_d, // Table 0 input d
  input wire logic [3:0] tab1_a, // Table 1 input a
  input wire logic [3:0] tab1_b, // Table 1 input b
  input wire logic [3:0] tab1_c, // Table 1 input c
  input wire logic [3:0] tab1_d, // Table 1 input d
  input wire logic [3:0] multipurpose_input_zero, // Mux select / write data bit 0
  input wire logic [3:0] multipurpose_input_one, // Wide mux select / write data bit 1
  input wire logic [3:0] clock_enable, // Storage clock enable
  input wire logic [3:0] local_set_reset, // Storage set/reset
  input wire logic [3:0] slice_clock, // Routed slice clock
  input wire logic carry_chain_in, // Carry from the previous unit
  output logic [3:0] table_bypass_out_zero, // Table 0 result
  output logic [3:0] table_bypass_out_one, // Table 1 result
  output logic [3:0] storage_out_zero, // Storage cell 0
  output logic [3:0] storage_out_one, // Storage cell 1
  output logic [3:0] wide_mux_out_zero, // Five-input mux
  output logic [3:0] wide_mux_out_one, // Six/seven/eight-input mux
  output logic carry_chain_out // Carry to the next unit
);
  import slice_pkg::*;

  typedef struct packed
  {
    logic [SLICES-1:0][CFG_W-1:0] cfg;
    logic dual;
    logic [SLICES-1:0][1:0][TABLE_DEPTH-1:0] tab;
    logic [SLICES-1:0] clk_prev;
    logic [31:0] rdata;
    logic slverr;
  } unit_state_type;

  unit_state_type s_q;
  unit_state_type s_d;

  logic [SLICES-1:0][1:0] f;
  logic [SLICES-1:0][1:0] q;
  logic [SLICES-1:0] five_mux;
  logic [SLICES-1:0] chain_mux;
  logic [SLICES:0] carry;
  logic [SLICES-1:0] gen;
  logic [SLICES-1:0] prop;
  logic [SLICES-1:0][3:0] idx0;
  logic [SLICES-1:0][3:0] idx1;
  logic [SLICES-1:0][1:0] xo;
  logic [SLICES-1:0][1:0] yo;
  logic [SLICES-1:0][1:0] go;
  logic [SLICES-1:0][1:0] po;
  logic [SLICES-1:0] c1;
  logic [SLICES-1:0] ev;
  logic [SLICES-1:0] ram_we;
  logic [1:0] a_op [SLICES];
  logic [1:0] b_op [SLICES];

  // Table lookup and ripple arithmetic per slice
  always_comb
  begin
    carry[0] = carry_chain_in;
    for (int i = 0; i < SLICES; i++)
    begin
      a_op[i] = {tab1_a[i], tab0_a[i]};
      b_op[i] = {tab1_b[i], tab0_b[i]};
      idx0[i] = {tab0_d[i], tab0_c[i], tab0_b[i], tab0_a[i]};
      // Single-port RAM shares one address across both bits
      if (s_q.cfg[i][CFG_MODE_LSB+:4] == MODE_RAM)
        idx1[i] = idx0[i];
      else
        idx1[i] = {tab1_d[i], tab1_c[i], tab1_b[i], tab1_a[i]};
      xo[i] = a_op[i];
      yo[i] = b_op[i];
      case (s_q.cfg[i][CFG_OP_LSB+:9])
        OP_ADD: yo[i] = b_op[i];
        OP_SUB: yo[i] = ~b_op[i];
        OP_ADDSUB: yo[i] = multipurpose_input_zero[i] ? b_op[i] : ~b_op[i];
        OP_UP:
        begin
          xo[i] = q[i];
          yo[i] = 2'b00;
        end
        OP_DOWN:
        begin
          xo[i] = q[i];
          yo[i] = 2'b11;
        end
        OP_MULT: xo[i] = a_op[i] & {2{multipurpose_input_zero[i]}};
        OP_GE: yo[i] = ~b_op[i];
        OP_LE:
        begin
          xo[i] = b_op[i];
          yo[i] = ~a_op[i];
        end
        default: yo[i] = b_op[i];
      endcase
      go[i] = xo[i] & yo[i];
      po[i] = xo[i] ^ yo[i];
      c1[i] = go[i][0] | (po[i][0] & carry[i]);
      gen[i] = go[i][1] | (po[i][1] & go[i][0]);
      prop[i] = po[i][1] & po[i][0];
      if (s_q.cfg[i][CFG_MODE_LSB+:4] == MODE_RIPPLE)
      begin
        f[i] = {po[i][1] ^ c1[i], po[i][0] ^ carry[i]};
        if (s_q.cfg[i][CFG_OP_LSB+:9] == OP_NE)
          carry[i+1] = carry[i] | (a_op[i] != b_op[i]);
        else
          carry[i+1] = gen[i] | (prop[i] & carry[i]);
      end
      else
      begin
        // Non-ripple slices pass the chain through untouched
        f[i] = {s_q.tab[i][1][idx1[i]], s_q.tab[i][0][idx0[i]]};
        carry[i+1] = carry[i];
      end
      five_mux[i] = multipurpose_input_zero[i] ? f[i][1] : f[i][0];
    end
  end

  // Wide-function muxes chained across slices
  always_comb
  begin
    chain_mux[0] = multipurpose_input_one[0] ? five_mux[1] : five_mux[0];
    chain_mux[2] = multipurpose_input_one[2] ? five_mux[3] : five_mux[2];
    chain_mux[1] = multipurpose_input_one[1] ? chain_mux[2] : chain_mux[0];
    // The neighbour unit's seven-input result arrives on the inter-unit path
    chain_mux[3] = multipurpose_input_one[3] ? carry_chain_in : chain_mux[1];
  end

  // Slice clock events that drive RAM writes
  always_comb
  begin
    for (int i = 0; i < SLICES; i++)
    begin
      ev[i] = s_q.cfg[i][CFG_NEGCLK_BIT] ? (s_q.clk_prev[i] & ~slice_clock[i])
                                         : (~s_q.clk_prev[i] & slice_clock[i]);
      ram_we[i] = HAS_RAM && (s_q.cfg[i][CFG_MODE_LSB+:4] == MODE_RAM)
                  && ev[i] && clock_enable[i];
    end
  end

  // Next state: RAM writes, then APB configuration access
  always_comb
  begin
    int src;
    logic hit;
    logic [1:0] sl;
    logic [31:0] rd;
    src = 0;
    sl = paddr[5:4];
    hit = 1'b0;
    rd = 32'h0000_0000;
    s_d = s_q;
    s_d.clk_prev = slice_clock;
    for (int i = 0; i < SLICES; i++)
    begin
      // Odd slice of a dual-port pair mirrors its partner's writes
      src = (s_q.dual && i[0]) ? i - 1 : i;
      if (ram_we[src] && ((src == i) || (s_q.cfg[i][CFG_MODE_LSB+:4] == MODE_RAM)))
      begin
        s_d.tab[i][0][idx0[src]] = multipurpose_input_zero[src];
        s_d.tab[i][1][idx0[src]] = multipurpose_input_one[src];
      end
    end
    // Decode
    if (paddr[7:6] == 2'b00 && paddr[3:0] == CFG_OFS)
    begin
      hit = 1'b1;
      rd = {15'h0000, s_q.cfg[sl]};
    end
    else if (paddr[7:6] == 2'b00 && paddr[3:0] == TABLE_OFS)
    begin
      hit = 1'b1;
      rd = {s_q.tab[sl][1], s_q.tab[sl][0]};
    end
    else if (paddr == UNIT_CTRL_ADDR)
    begin
      hit = 1'b1;
      rd = {31'h0000_0000, s_q.dual};
    end
    else if (paddr == UNIT_STATUS_ADDR)
    begin
      hit = 1'b1;
      rd = {23'h00_0000, carry_chain_out, q};
    end
    // Read data latched in the setup cycle, answered in the access cycle
    if (psel && !penable)
    begin
      s_d.rdata = pwrite ? 32'h0000_0000 : rd;
      s_d.slverr = ~hit;
    end
    if (psel && penable && pwrite && hit)
    begin
      if (paddr[7:6] == 2'b00 && paddr[3:0] == CFG_OFS)
      begin
        s_d.cfg[sl] = pwdata[CFG_W-1:0];
        // The reduced variant turns a RAM request into ROM
        if (!HAS_RAM && pwdata[CFG_MODE_LSB+:4] == MODE_RAM)
          s_d.cfg[sl][CFG_MODE_LSB+:4] = MODE_ROM;
      end
      else if (paddr[7:6] == 2'b00 && paddr[3:0] == TABLE_OFS)
      begin
        // Configuration load wins over a same-cycle RAM write
        s_d.tab[sl] = pwdata;
      end
      else if (paddr == UNIT_CTRL_ADDR)
      begin
        s_d.dual = pwdata[CTRL_DUAL_BIT];
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.cfg <= {SLICES{CFG_RESET}};
      s_q.dual <= CTRL_DUAL_RESET;
      s_q.tab <= {(2*SLICES){TABLE_RESET}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Two storage cells per slice
  for (genvar g = 0; g < 2 * SLICES; g++)
  begin : gen_cell
    storage_cell u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .d(f[g/2][g%2]),
      .slice_clock(slice_clock[g/2]),
      .clock_enable(clock_enable[g/2]),
      .local_set_reset(local_set_reset[g/2]),
      .latch_mode(s_q.cfg[g/2][CFG_LATCH_BIT]),
      .neg_clk(s_q.cfg[g/2][CFG_NEGCLK_BIT]),
      .sync_sr(s_q.cfg[g/2][CFG_SYNC_BIT]),
      .sr_val(s_q.cfg[g/2][CFG_SRVAL_BIT]),
      .q(q[g/2][g%2])
    );
  end

  // Outputs: 6 routed per slice plus the chain end
  always_comb
  begin
    for (int i = 0; i < SLICES; i++)
    begin
      table_bypass_out_zero[i] = f[i][0];
      table_bypass_out_one[i] = f[i][1];
      storage_out_zero[i] = q[i][0];
      storage_out_one[i] = q[i][1];
      wide_mux_out_zero[i] = five_mux[i];
      wide_mux_out_one[i] = chain_mux[i];
    end
  end

  assign carry_chain_out = carry[SLICES];
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & s_q.slverr;

  // Checks
  property p_add;
    @(posedge pclk) disable iff (!presetn)
    (s_q.cfg[0][3:0] == MODE_RIPPLE && s_q.cfg[0][16:8] == OP_ADD)
      |-> ({carry[1], f[0]} == 3'(a_op[0]) + 3'(b_op[0]) + 3'(carry[0]));
  endproperty
  a_add: assert property (p_add) else $error("slice 0 add wrong");

  property p_carry;
    @(posedge pclk) disable iff (!presetn)
    (s_q.cfg[1][3:0] == MODE_RIPPLE && s_q.cfg[1][16:8] != OP_NE)
      |-> (carry[2] == (gen[1] | (prop[1] & carry[1])));
  endproperty
  a_carry: assert property (p_carry) else $error("carry chain wrong");

  property p_five;
    @(posedge pclk) disable iff (!presetn)
    (s_q.cfg[0][3:0] == MODE_LOGIC)
      |-> (five_mux[0] == s_q.tab[0][multipurpose_input_zero[0]]
           [multipurpose_input_zero[0] ? idx1[0] : idx0[0]]);
  endproperty
  a_five: assert property (p_five) else $error("five-input mux wrong");

  property p_ram_write;
    @(posedge pclk) disable iff (!presetn)
    (ram_we[0] && !(psel && penable && pwrite))
      |=> (s_q.tab[0][0][$past(idx0[0])] == $past(multipurpose_input_zero[0]));
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("RAM write lost");

  property p_rom_hold;
    @(posedge pclk) disable iff (!presetn)
    (s_q.cfg[2][3:0] == MODE_ROM && !(psel && penable && pwrite)) |=> $stable(s_q.tab[2]);
  endproperty
  a_rom_hold: assert property (p_rom_hold) else $error("ROM contents changed");

  property p_no_ram;
    @(posedge pclk) disable iff (!presetn)
    !HAS_RAM |-> (s_q.cfg[3][3:0] != MODE_RAM);
  endproperty
  a_no_ram: assert property (p_no_ram) else $error("RAM mode in reduced unit");

  property p_cfg_write;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && paddr == UNIT_CTRL_ADDR)
      |=> (s_q.dual == $past(pwdata[CTRL_DUAL_BIT]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("control write lost");
endmodule

// ==== rtl/slice_pkg.sv ====
// Constants, modes and register map shared by the function unit and its storage cells
package slice_pkg;
  // Unit shape
  localparam int SLICES = 4;
  localparam int TABLE_DEPTH = 16;
  localparam int ADDR_W = 8;

  // Slice operating modes, one-hot
  typedef enum logic [3:0]
  {
    MODE_LOGIC = 4'h1,
    MODE_RIPPLE = 4'h2,
    MODE_RAM = 4'h4,
    MODE_ROM = 4'h8
  } mode_type;

  // Ripple-mode functions, one-hot
  typedef enum logic [8:0]
  {
    OP_ADD = 9'h001,
    OP_SUB = 9'h002,
    OP_ADDSUB = 9'h004,
    OP_UP = 9'h008,
    OP_DOWN = 9'h010,
    OP_MULT = 9'h020,
    OP_GE = 9'h040,
    OP_NE = 9'h080,
    OP_LE = 9'h100
  } ripple_op_type;

  // Register offsets; slice n sits at n * SLICE_STRIDE
  localparam logic [ADDR_W-1:0] SLICE_STRIDE = 8'h10;
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] TABLE_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] UNIT_CTRL_ADDR = 8'h40;
  localparam logic [ADDR_W-1:0] UNIT_STATUS_ADDR = 8'h44;

  // Slice configuration word fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_LATCH_BIT = 4;
  localparam int CFG_NEGCLK_BIT = 5;
  localparam int CFG_SYNC_BIT = 6;
  localparam int CFG_SRVAL_BIT = 7;
  localparam int CFG_OP_LSB = 8;
  localparam int CFG_W = 17;
  localparam int CTRL_DUAL_BIT = 0;

  // Reset values
  localparam logic [CFG_W-1:0] CFG_RESET = 17'h00001;
  localparam logic [15:0] TABLE_RESET = 16'h0000;
  localparam logic CTRL_DUAL_RESET = 1'b0;
endpackage

// ==== rtl/storage_cell.sv ====
// One slice storage element: flip-flop or latch with clock enable and set/reset
`timescale 1ns/1ps
module storage_cell (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic d, // Data from the table output
  input wire logic slice_clock, // Routed slice clock, sampled on pclk
  input wire logic clock_enable, // Clock enable
  input wire logic local_set_reset, // Local set/reset
  input wire logic latch_mode, // 1: level latch, 0: edge flip-flop
  input wire logic neg_clk, // 1: falling edge or low level active
  input wire logic sync_sr, // 1: set/reset waits for a clock event
  input wire logic sr_val, // Value forced by set/reset
  output logic q // Stored value
);
  import slice_pkg::*;

  typedef struct packed
  {
    logic q;
    logic clk_prev;
  } cell_state_type;

  cell_state_type s_q;
  cell_state_type s_d;
  logic edge_ev;
  logic level_open;
  logic clocked;

  // Clock event detection and next value
  always_comb
  begin
    edge_ev = neg_clk ? (s_q.clk_prev & ~slice_clock) : (~s_q.clk_prev & slice_clock);
    level_open = slice_clock ^ neg_clk;
    clocked = latch_mode ? level_open : edge_ev;
    s_d = s_q;
    s_d.clk_prev = slice_clock;
    if (local_set_reset && !sync_sr)
    begin
      s_d.q = sr_val;
    end
    else if (clocked && local_set_reset)
    begin
      s_d.q = sr_val;
    end
    else if (clocked && clock_enable)
    begin
      s_d.q = d;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign q = s_q.q;

  // Checks
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (!local_set_reset && !(clocked && clock_enable)) |=> $stable(q);
  endproperty
  a_hold: assert property (p_hold) else $error("storage changed without event");

  property p_async_sr;
    @(posedge pclk) disable iff (!presetn)
    (local_set_reset && !sync_sr) |=> (q == $past(sr_val));
  endproperty
  a_async_sr: assert property (p_async_sr) else $error("async set/reset missed");

  property p_sync_wait;
    @(posedge pclk) disable iff (!presetn)
    (local_set_reset && sync_sr && !clocked) |=> $stable(q);
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("sync set/reset acted early");

  sequence s_active_edge;
    (neg_clk ? $fell(slice_clock) : $rose(slice_clock));
  endsequence

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
    (!latch_mode && clock_enable && !local_set_reset) ##0 s_active_edge |=> (q == $past(d));
  endproperty
  a_capture: assert property (p_capture) else $error("edge capture wrong");
endmodule

// ==== testbench/fabric_model.sv ====
// Routing fabric model that drives the unit's fabric-side inputs
`timescale 1ns/1ps
module fabric_model (
  input wire logic pclk, // Fabric clock
  output logic [3:0] tab0_a, // Table 0 input a
  output logic [3:0] tab0_b, // Table 0 input b
  output logic [3:0] tab0_c, // Table 0 input c
  output logic [3:0] tab0_d, // Table 0 input d
  output logic [3:0] tab1_a, // Table 1 input a
  output logic [3:0] tab1_b, // Table 1 input b
  output logic [3:0] tab1_c, // Table 1 input c
  output logic [3:0] tab1_d, // Table 1 input d
  output logic [3:0] mp0, // Multipurpose input zero
  output logic [3:0] mp1, // Multipurpose input one
  output logic [3:0] ce, // Clock enable
  output logic [3:0] sr, // Local set/reset
  output logic [3:0] sclk, // Routed slice clock
  output logic cin // Carry into the unit
);
  // Quiet fabric at time zero
  initial
  begin
    {tab0_a, tab0_b, tab0_c, tab0_d, tab1_a, tab1_b, tab1_c, tab1_d} = '0;
    {mp0, mp1, ce, sr, sclk} = '0;
    cin = 1'b0;
  end

  // Same index on every slice, so each slice sees identical routing
  task set_idx(input logic [3:0] i0, input logic [3:0] i1);
    @(posedge pclk);
    {tab0_d, tab0_c, tab0_b, tab0_a} <= {{4{i0[3]}}, {4{i0[2]}}, {4{i0[1]}}, {4{i0[0]}}};
    {tab1_d, tab1_c, tab1_b, tab1_a} <= {{4{i1[3]}}, {4{i1[2]}}, {4{i1[1]}}, {4{i1[0]}}};
  endtask

  // Control lines, launched just after an edge like real fabric logic
  task set_ctl(input logic c, input logic r, input logic [1:0] m, input logic ci);
    @(posedge pclk);
    ce <= {4{c}};
    sr <= {4{r}};
    mp0 <= {4{m[0]}};
    mp1 <= {4{m[1]}};
    cin <= ci;
  endtask

  // Slice clock level; edges are seen one pclk later by the unit
  task clk_to(input logic v);
    @(posedge pclk);
    sclk <= {4{v}};
  endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the four-slice function unit
`timescale 1ns/1ps
module tb;
  import slice_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cin, cout, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] t0a, t0b, t0c, t0d, t1a, t1b, t1c, t1d, mp0, mp1, ce, sr, sclk;
  logic [3:0] fo0, fo1, st0, st1, x0, x1;
  int fails, check_count;

  programmable_function_unit i_programmable_function_unit (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tab0_a(t0a), .tab0_b(t0b),
    .tab0_c(t0c), .tab0_d(t0d), .tab1_a(t1a), .tab1_b(t1b), .tab1_c(t1c), .tab1_d(t1d),
    .multipurpose_input_zero(mp0), .multipurpose_input_one(mp1), .clock_enable(ce),
    .local_set_reset(sr), .slice_clock(sclk), .carry_chain_in(cin),
    .table_bypass_out_zero(fo0), .table_bypass_out_one(fo1), .storage_out_zero(st0),
    .storage_out_one(st1), .wide_mux_out_zero(x0), .wide_mux_out_one(x1),
    .carry_chain_out(cout));

  fabric_model i_fabric_model (.pclk(pclk), .tab0_a(t0a), .tab0_b(t0b), .tab0_c(t0c),
    .tab0_d(t0d), .tab1_a(t1a), .tab1_b(t1b), .tab1_c(t1c), .tab1_d(t1d), .mp0(mp0),
    .mp1(mp1), .ce(ce), .sr(sr), .sclk(sclk), .cin(cin));

  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; data and error taken at the edge that sees pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] ra(input int n, input logic [3:0] ofs);
    return 8'(n * SLICE_STRIDE + ofs);
  endfunction

  // Storage needs one pclk to show a sampled edge, so wait three
  task settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task pulse;
    i_fabric_model.clk_to(1'b1);
    settle;
    i_fabric_model.clk_to(1'b0);
    settle;
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog well beyond the several hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("watchdog expired");
    finish_test;
  end

  // Main sequence
  initial
  begin
    logic [31:0] tv;
    int s;
    int ec;
    ripple_op_type ops [6];
    ops = '{OP_ADD, OP_SUB, OP_GE, OP_LE, OP_NE, OP_ADDSUB};
    tv = 32'h0F0F_A5C3;
    {psel, penable, pwrite, err} = '0;
    paddr = '0;
    pwdata = '0;
    rd = '0;
    presetn = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ra(0, CFG_OFS), '0);
    check("cfg reset", rd, 32'(CFG_RESET));
    apb(1'b0, ra(0, TABLE_OFS), '0);
    check("table reset", rd, 32'h0000_0000);
    apb(1'b0, UNIT_CTRL_ADDR, '0);
    check("ctrl reset", rd, 32'h0000_0000);
    apb(1'b1, ra(1, CFG_OFS), 32'hFFFE_0102);
    apb(1'b0, ra(1, CFG_OFS), '0);
    check("cfg upper bits", rd, 32'h0000_0102);
    apb(1'b0, 8'h48, '0);
    check("unmapped error", 32'(err), 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, ra(1, CFG_OFS), 32'h0000_0001);
    $display("test registers done");
    // Every index of both tables, wide mux steered to table 1
    apb(1'b1, ra(0, TABLE_OFS), tv);
    i_fabric_model.set_ctl(1'b0, 1'b0, 2'b01, 1'b0);
    for (int k = 0; k < 16; k++)
    begin
      i_fabric_model.set_idx(k[3:0], k[3:0]);
      settle;
      check("table0 out", 32'(fo0[0]), 32'(tv[k]));
      check("table1 out", 32'(fo1[0]), 32'(tv[16+k]));
      check("wide mux", 32'(x0[0]), 32'(tv[16+k]));
      check("wide mux chain", 32'(x1[3]), 32'(tv[16+k]));
    end
    $display("test logic done");
    // Storage: enable, polarity, async and sync set/reset
    apb(1'b1, ra(0, TABLE_OFS), 32'h0000_0001);
    i_fabric_model.set_idx(4'h0, 4'h0);
    i_fabric_model.set_ctl(1'b1, 1'b0, 2'b00, 1'b0);
    pulse;
    check("q capture", 32'(st0[0]), 32'h1);
    i_fabric_model.set_ctl(1'b0, 1'b0, 2'b00, 1'b0);
    i_fabric_model.set_idx(4'h1, 4'h1);
    pulse;
    check("q hold", 32'(st0[0]), 32'h1);
    i_fabric_model.set_ctl(1'b1, 1'b0, 2'b00, 1'b0);
    apb(1'b1, ra(0, CFG_OFS), 32'h0000_0021);
    i_fabric_model.clk_to(1'b1);
    settle;
    check("neg rise ignored", 32'(st0[0]), 32'h1);
    i_fabric_model.clk_to(1'b0);
    settle;
    check("neg fall", 32'(st0[0]), 32'h0);
    apb(1'b1, ra(0, CFG_OFS), 32'h0000_0001);
    i_fabric_model.set_idx(4'h0, 4'h0);
    pulse;
    i_fabric_model.set_ctl(1'b1, 1'b1, 2'b00, 1'b0);
    settle;
    check("async reset", 32'(st0[0]), 32'h0);
    apb(1'b1, ra(0, CFG_OFS), 32'h0000_00C1);
    settle;
    check("sync waits", 32'(st0[0]), 32'h0);
    pulse;
    check("sync set", 32'(st0[0]), 32'h1);
    check("sync set cell one", 32'(st1[0]), 32'h1);
    apb(1'b0, UNIT_STATUS_ADDR, '0);
    check("status", rd, 32'h0000_0003);
    i_fabric_model.set_ctl(1'b1, 1'b0, 2'b00, 1'b0);
    // Level latch: follows the table while the slice clock is high, holds while low
    apb(1'b1, ra(0, CFG_OFS), 32'h0000_0011);
    i_fabric_model.set_idx(4'h1, 4'h1);
    i_fabric_model.clk_to(1'b1);
    settle;
    check("latch open", 32'(st0[0]), 32'h0);
    i_fabric_model.set_idx(4'h0, 4'h0);
    settle;
    check("latch follows", 32'(st0[0]), 32'h1);
    i_fabric_model.clk_to(1'b0);
    i_fabric_model.set_idx(4'h1, 4'h1);
    settle;
    check("latch closed", 32'(st0[0]), 32'h1);
    $display("test storage done");
    // Ripple add, subtract, compares and dynamic add over all 2-bit operands
    for (int o = 0; o < 6; o++)
    begin
      apb(1'b1, ra(0, CFG_OFS), {15'h0, ops[o], 8'h02});
      // Sub and the magnitude compares start the chain with carry 1; add/sub steered to add
      i_fabric_model.set_ctl(1'b1, 1'b0, (o == 5) ? 2'b01 : 2'b00, (o > 0 && o < 4));
      for (int a = 0; a < 4; a++)
        for (int b = 0; b < 4; b++)
        begin
          i_fabric_model.set_idx({2'b00, b[0], a[0]}, {2'b00, b[1], a[1]});
          settle;
          s = (o == 0 || o == 5) ? a + b : a - b + 4;
          ec = (s >> 2) & 1;
          if (o == 2)
            ec = (a >= b);
          else if (o == 3)
            ec = (a <= b);
          else if (o == 4)
            ec = (a != b);
          if (o < 2 || o == 5)
            check("ripple sum", 32'({fo1[0], fo0[0]}), 32'(s & 3));
          check("carry out", 32'(cout), 32'(ec));
        end
    end
    $display("test ripple done");
    // RAM writes on the slice clock, reads follow the address; slice 1 is the read-only port
    apb(1'b1, UNIT_CTRL_ADDR, 32'h0000_0001);
    apb(1'b1, ra(1, CFG_OFS), 32'h0000_0004);
    apb(1'b1, ra(0, CFG_OFS), 32'h0000_0004);
    for (int w = 0; w < 2; w++)
    begin
      i_fabric_model.set_ctl(1'b1, 1'b0, w ? 2'b01 : 2'b10, 1'b0);
      i_fabric_model.set_idx(w ? 4'h6 : 4'h5, w ? 4'h6 : 4'h5);
      pulse;
    end
    i_fabric_model.set_idx(4'h5, 4'h5);
    settle;
    check("ram read", 32'({fo1[0], fo0[0]}), 32'h2);
    check("dual read port", 32'({fo1[1], fo0[1]}), 32'h2);
    apb(1'b0, ra(0, TABLE_OFS), '0);
    check("ram contents", rd & 32'h0060_0060, 32'h0020_0040);
    apb(1'b1, ra(0, CFG_OFS), 32'h0000_0008);
    i_fabric_model.set_ctl(1'b1, 1'b0, 2'b01, 1'b0);
    pulse;
    check("rom no write", 32'({fo1[0], fo0[0]}), 32'h2);
    $display("test memory done");
    finish_test;
  end
endmodule
